// ### isma_pkg.sv
// Function
// - Master issues stop only after the transmitter has released the data line.
// - Transmitter releases data after eight bits; receiver pulls it low on ninth clock.
// - After withholding acknowledge in a read, master issues a stop.
// - Byte write is slave byte, word address, one data byte; stop starts write.
// - Master never writes addresses 58H to 7FH or above ABH.
// - Read is requested by a one in the slave byte direction bit.
// - To end a read the master leaves data high on the ninth clock then stops.
// - Random read is write slave byte, word address, repeated start, read slave byte.
// - Nonvolatile accesses use single bytes, writes spaced at least 30 ms apart; code refuses multi-byte and zero-length writes, reads of any nonzero length go out.
// - Nonvolatile read of a page's first byte recalls over 200 us; read it twice; code repeats only random reads starting there, not current reads.
// - Nonvolatile write of a page's first byte is done twice, 30 ms apart and after.
// - Nonvolatile writes cover whole pages without reads between, or use page write.
// - Every byte on the bus travels most significant bit first.
package isma_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_KHZ = 125000;
   localparam int SCL_KHZ = 400;
   localparam int QTR_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
   localparam int QTR_W = 8;
   localparam longint EE_WR_GAP_US = 30000;
   localparam longint EE_RECALL_US = 200;
   localparam int EE_WR_GAP_CYC = int'((EE_WR_GAP_US * CLK_KHZ + 999) / 1000);
   localparam int EE_RECALL_CYC = int'((EE_RECALL_US * CLK_KHZ + 999) / 1000);
   localparam int GAP_W = 22;

   // ************************************************************
   // Addresses and counts
   // ************************************************************
   localparam logic [7:0] RSV_LO_ADDR = 8'h58;
   localparam logic [7:0] RSV_HI_ADDR = 8'h7f;
   localparam logic [7:0] TOP_ADDR = 8'hab;
   localparam logic [1:0] PAGE_OFS_FIRST = 2'h0;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;

   typedef enum logic [1:0] {OP_WRITE = 2'b00, OP_RAND_READ = 2'b01, OP_CUR_READ = 2'b10} isma_op_type;
   typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_START = 3'b001, ST_BIT = 3'b010, ST_RSTART = 3'b011,
                             ST_STOP = 3'b100, ST_GAP = 3'b101} isma_state_type;
   typedef enum logic [2:0] {SQ_SLAVE = 3'b000, SQ_ADDR = 3'b001, SQ_WDATA = 3'b010, SQ_SLAVE_R = 3'b011,
                             SQ_RDATA = 3'b100} isma_step_type;

   // Address that must never be written
   function automatic logic isma_reserved(input logic [7:0] addr);
      isma_reserved = (addr >= RSV_LO_ADDR && addr <= RSV_HI_ADDR) || addr > TOP_ADDR;
   endfunction

endpackage

// ### isma_host.sv
`timescale 1ns/1ps
`default_nettype none
module isma_host import isma_pkg::*; #(
   parameter int QTR_CYC_P = QTR_CYC,
   parameter int WR_GAP_CYC = EE_WR_GAP_CYC,
   parameter int RECALL_CYC = EE_RECALL_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_op,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_len,
   input wire logic memory_select_bit,
   input wire logic [6:0] slave_addr,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   output logic nack_err,
   output logic refused,
   output logic busy,
   output logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);

   // ************************************************************
   // Registers
   // ************************************************************
   isma_state_type state_reg;
   isma_step_type step_reg;
   isma_op_type op_reg;
   logic [QTR_W-1:0] qtr_cnt_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] byte_reg, wdata_reg, rx_reg, len_reg, len_init_reg, rd_data_reg, cmd_addr_reg;
   logic [GAP_W-1:0] gap_cnt_reg;
   logic ack_reg, have_byte_reg, ee_reg, repeat_reg, discard_reg;
   logic sda_meta_reg, sda_sync_reg, sda_dly_reg, scl_reg, sda_oe_n_reg;
   logic cmd_ready_reg, wr_ready_reg, rd_valid_reg, done_reg, nack_err_reg, refused_reg, busy_reg;
   logic stall, run, tick, ninth, is_rx, last_byte, tx_bit;
   logic line_scl, line_sda, cmd_take, cmd_bad, page_first;

   // ************************************************************
   // Pin synchroniser
   // ************************************************************

   // Two flops before the data line is looked at
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
      end
      else
      begin
         sda_meta_reg <= sda_i;
         sda_sync_reg <= sda_meta_reg;
      end
   end

   // ************************************************************
   // Decode
   // ************************************************************

   // Bit and byte context
   assign ninth = bit_cnt_reg == ACK_BIT;
   assign is_rx = step_reg == SQ_RDATA;
   assign last_byte = len_reg == ONE_BYTE;
   assign tx_bit = (step_reg == SQ_WDATA) ? wdata_reg[3'(7 - bit_cnt_reg)] : byte_reg[3'(7 - bit_cnt_reg)];
   assign stall = state_reg == ST_BIT && step_reg == SQ_WDATA && !have_byte_reg;
   assign run = state_reg != ST_IDLE && state_reg != ST_GAP && !stall;
   assign tick = run && qtr_cnt_reg == QTR_W'(QTR_CYC_P - 1);
   assign cmd_take = cmd_valid && cmd_ready_reg;
   assign page_first = cmd_addr[1:0] == PAGE_OFS_FIRST;
   // Writes to reserved space or multi-byte nonvolatile writes are refused
   assign cmd_bad = cmd_len == BYTE_RST || (cmd_op == OP_WRITE && (isma_reserved(cmd_addr)
                    || (memory_select_bit && cmd_len != ONE_BYTE)));

   // Wanted level of clock and data for the current phase
   always_comb
   begin
      line_scl = 1'b1;
      line_sda = 1'b1;
      case (state_reg)
         ST_START:
         begin
            line_scl = !phase_reg[1];
            line_sda = phase_reg == 2'h0;
         end
         ST_RSTART:
         begin
            line_scl = phase_reg == 2'h1 || phase_reg == 2'h2;
            line_sda = phase_reg[1] == 1'b0;
         end
         ST_STOP:
         begin
            line_scl = phase_reg != 2'h0;
            line_sda = phase_reg[1];
         end
         ST_BIT:
         begin
            line_scl = phase_reg[1];
            if (ninth)
               line_sda = is_rx ? last_byte : 1'b1;
            else
               line_sda = is_rx ? 1'b1 : tx_bit;
         end
         default:
         begin
            line_scl = 1'b1;
            line_sda = 1'b1;
         end
      endcase
   end

   // ************************************************************
   // Bit timebase
   // ************************************************************

   // Quarter period counter and phase
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         qtr_cnt_reg <= '0;
         phase_reg <= 2'h0;
      end
      else if (!run)
      begin
         qtr_cnt_reg <= '0;
         phase_reg <= 2'h0;
      end
      else if (tick)
      begin
         qtr_cnt_reg <= '0;
         phase_reg <= phase_reg + 2'h1;
      end
      else
         qtr_cnt_reg <= qtr_cnt_reg + QTR_W'(1);
   end

   // ************************************************************
   // Transfer engine
   // ************************************************************

   // Command, byte sequence and read data
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_IDLE;
         step_reg <= SQ_SLAVE;
         op_reg <= OP_WRITE;
         bit_cnt_reg <= BIT_CNT_RST;
         byte_reg <= BYTE_RST;
         wdata_reg <= BYTE_RST;
         rx_reg <= BYTE_RST;
         len_reg <= BYTE_RST;
         len_init_reg <= BYTE_RST;
         gap_cnt_reg <= '0;
         ack_reg <= 1'b1;
         have_byte_reg <= 1'b0;
         ee_reg <= 1'b0;
         repeat_reg <= 1'b0;
         discard_reg <= 1'b0;
         rd_valid_reg <= 1'b0;
         rd_data_reg <= BYTE_RST;
         done_reg <= 1'b0;
         nack_err_reg <= 1'b0;
         refused_reg <= 1'b0;
      end
      else
      begin
         rd_valid_reg <= 1'b0;
         done_reg <= 1'b0;
         nack_err_reg <= 1'b0;
         refused_reg <= 1'b0;
         if (wr_valid && wr_ready_reg)
         begin
            wdata_reg <= wr_data;
            have_byte_reg <= 1'b1;
         end
         case (state_reg)
            ST_IDLE:
               if (cmd_take)
               begin
                  if (cmd_bad)
                  begin
                     refused_reg <= 1'b1;
                     done_reg <= 1'b1;
                  end
                  else
                  begin
                     op_reg <= isma_op_type'(cmd_op);
                     ee_reg <= memory_select_bit;
                     len_reg <= cmd_len;
                     len_init_reg <= cmd_len;
                     // First byte of a nonvolatile page is accessed twice, except in a current read
                     repeat_reg <= memory_select_bit && page_first && cmd_op != OP_CUR_READ;
                     discard_reg <= memory_select_bit && page_first && cmd_op == OP_RAND_READ;
                     have_byte_reg <= 1'b0;
                     byte_reg <= {slave_addr, cmd_op == OP_CUR_READ};
                     step_reg <= SQ_SLAVE;
                     state_reg <= ST_START;
                  end
               end
            ST_START, ST_RSTART:
               if (tick && phase_reg == 2'h3)
               begin
                  bit_cnt_reg <= BIT_CNT_RST;
                  state_reg <= ST_BIT;
               end
            ST_BIT:
               if (tick)
               begin
                  if (phase_reg == 2'h2)
                  begin
                     if (ninth)
                        ack_reg <= sda_sync_reg;
                     else
                        rx_reg <= {rx_reg[6:0], sda_sync_reg};
                  end
                  else if (phase_reg == 2'h3 && !ninth)
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  else if (phase_reg == 2'h3)
                  begin
                     bit_cnt_reg <= BIT_CNT_RST;
                     if (!is_rx && ack_reg)
                     begin
                        // Byte refused: give up, no repeat
                        nack_err_reg <= 1'b1;
                        repeat_reg <= 1'b0;
                        discard_reg <= 1'b0;
                        state_reg <= ST_STOP;
                     end
                     else
                        case (step_reg)
                           SQ_SLAVE:
                              if (op_reg == OP_CUR_READ)
                                 step_reg <= SQ_RDATA;
                              else
                              begin
                                 byte_reg <= cmd_addr_reg;
                                 step_reg <= SQ_ADDR;
                              end
                           SQ_ADDR:
                              if (op_reg == OP_WRITE)
                                 step_reg <= SQ_WDATA;
                              else
                              begin
                                 byte_reg <= {slave_addr, 1'b1};
                                 step_reg <= SQ_SLAVE_R;
                                 state_reg <= ST_RSTART;
                              end
                           SQ_SLAVE_R:
                              step_reg <= SQ_RDATA;
                           SQ_WDATA:
                           begin
                              // Repeat pass keeps the same byte
                              have_byte_reg <= repeat_reg;
                              len_reg <= len_reg - ONE_BYTE;
                              if (last_byte)
                                 state_reg <= ST_STOP;
                           end
                           default:
                           begin
                              if (!discard_reg)
                              begin
                                 rd_valid_reg <= 1'b1;
                                 rd_data_reg <= rx_reg;
                              end
                              len_reg <= len_reg - ONE_BYTE;
                              if (last_byte)
                                 state_reg <= ST_STOP;
                           end
                        endcase
                  end
               end
            ST_STOP:
               if (tick && phase_reg == 2'h3)
               begin
                  state_reg <= ST_GAP;
                  // Wait out nonvolatile write or page recall
                  if (ee_reg && op_reg == OP_WRITE && !nack_err_reg)
                     gap_cnt_reg <= GAP_W'(WR_GAP_CYC);
                  else if (discard_reg)
                     gap_cnt_reg <= GAP_W'(RECALL_CYC);
                  else
                     gap_cnt_reg <= '0;
               end
            ST_GAP:
               if (gap_cnt_reg != '0)
                  gap_cnt_reg <= gap_cnt_reg - GAP_W'(1);
               else if (repeat_reg)
               begin
                  repeat_reg <= 1'b0;
                  discard_reg <= 1'b0;
                  len_reg <= len_init_reg;
                  byte_reg <= {slave_addr, 1'b0};
                  step_reg <= SQ_SLAVE;
                  state_reg <= ST_START;
               end
               else
               begin
                  done_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // Word address held for the whole command
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cmd_addr_reg <= BYTE_RST;
      else if (cmd_take)
         cmd_addr_reg <= cmd_addr;
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Handshakes, status and pins from flops
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmd_ready_reg <= 1'b0;
         wr_ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_dly_reg <= 1'b1;
         sda_oe_n_reg <= 1'b1;
      end
      else
      begin
         cmd_ready_reg <= state_reg == ST_IDLE && !cmd_take;
         wr_ready_reg <= stall && !(wr_valid && wr_ready_reg);
         busy_reg <= state_reg != ST_IDLE || cmd_take;
         scl_reg <= line_scl;
         sda_dly_reg <= line_sda; // Data trails the clock so data bits move only while clock is low
         sda_oe_n_reg <= sda_dly_reg;
      end
   end

   assign cmd_ready = cmd_ready_reg;
   assign wr_ready = wr_ready_reg;
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   assign done = done_reg;
   assign nack_err = nack_err_reg;
   assign refused = refused_reg;
   assign busy = busy_reg;
   assign scl = scl_reg;
   assign sda_o = 1'b0;
   assign sda_oe_n = sda_oe_n_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_sda_stable_high: assert property (state_reg == ST_BIT && phase_reg == 2'h3 |-> $stable(sda_oe_n_reg))
      else $error("Data changed while clock high");
   a_tx_ack_release: assert property (state_reg == ST_BIT && ninth && !is_rx && phase_reg == 2'h2 |-> sda_oe_n_reg)
      else $error("Data not released on ninth clock");
   a_rd_last_nack: assert property (state_reg == ST_BIT && ninth && is_rx && last_byte && phase_reg == 2'h2
      |-> sda_oe_n_reg)
      else $error("Last read byte acknowledged");
   a_rd_more_ack: assert property (state_reg == ST_BIT && ninth && is_rx && !last_byte && phase_reg == 2'h2
      |-> !sda_oe_n_reg)
      else $error("Read byte not acknowledged");
   a_read_end_stop: assert property (tick && state_reg == ST_BIT && ninth && is_rx && last_byte && phase_reg == 2'h3
      |=> state_reg == ST_STOP ##2 (!scl_reg && !sda_oe_n_reg))
      else $error("No stop after last read byte");
   a_stop_edge: assert property (state_reg == ST_STOP && phase_reg == 2'h3 |-> scl_reg && sda_oe_n_reg)
      else $error("Stop not ended with data high under clock high");
   a_reserved_refused: assert property (cmd_take && cmd_op == OP_WRITE && isma_reserved(cmd_addr)
      |=> refused_reg && state_reg == ST_IDLE)
      else $error("Reserved address write not refused");
   a_rstart_read: assert property ($rose(step_reg == SQ_SLAVE_R) |-> state_reg == ST_RSTART)
      else $error("Read slave byte without repeated start");
   a_slave_rw: assert property (state_reg == ST_BIT && step_reg == SQ_SLAVE_R |-> byte_reg[0])
      else $error("Read slave byte with write direction");
   a_ee_gap: assert property ($rose(state_reg == ST_GAP) && ee_reg && op_reg == OP_WRITE && !nack_err_reg
      |-> gap_cnt_reg == GAP_W'(WR_GAP_CYC))
      else $error("Nonvolatile write spacing wrong");

   c_write_done: cover property (done_reg && op_reg == OP_WRITE && !refused_reg);
   c_rand_read: cover property (rd_valid_reg && op_reg == OP_RAND_READ);
   c_cur_read: cover property (rd_valid_reg && op_reg == OP_CUR_READ);
   c_ee_repeat: cover property (state_reg == ST_GAP && repeat_reg && gap_cnt_reg == '0);

endmodule // isma_host
`default_nettype wire

// ### isma_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Slave device model
// ****
module isma_dev_model #(
   parameter logic [6:0] DEV_ADDR = 7'h28,
   parameter logic [7:0] PROT_ADDR = 8'h41,
   parameter int WR_NS = 100
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic nv_sel,
   output logic pull_low
);
   logic [7:0] mem [512];
   logic [7:0] sh_reg;
   logic [7:0] ptr_reg;
   logic act = 1'b0;
   logic rd = 1'b0;
   logic rc = 1'b0;
   int bc = 0;
   int nb = 0;
   time busy_until = 0;
   // Known contents, address xor a5
   initial
   begin
      pull_low = 1'b0;
      for (int i = 0; i < 512; i++)
         mem[i] = 8'(i) ^ 8'ha5;
   end
   // Start or repeated start
   always @(negedge sda)
      if (scl && $time >= busy_until)
      begin
         act = 1'b1;
         rd = 1'b0;
         bc = 0;
         nb = 0;
      end
   // Stop returns to standby
   always @(posedge sda)
      if (scl)
      begin
         // Stop after an accepted nonvolatile data byte starts the write cycle
         if (act && !rd && nb > 2 && nv_sel)
            busy_until = $time + WR_NS;
         act = 1'b0;
      end
   // Sample bits and the master acknowledge
   always @(posedge scl)
      if (act)
      begin
         if (bc < 8 && !rd)
            sh_reg = {sh_reg[6:0], sda};
         if (bc == 8 && rd && nb > 0 && sda)
            act = 1'b0;
         bc = bc + 1;
      end
   // Drive acknowledge and read data while the clock is low
   always @(negedge scl)
      if (act)
      begin
         pull_low = 1'b0;
         if (bc == 8 && (!rd || nb == 0))
         begin
            act = (nb != 0) || (sh_reg[7:1] == DEV_ADDR);
            if (nb == 0)
               rd = sh_reg[0];
            else if (nb == 1)
               ptr_reg = sh_reg;
            else if (nv_sel && ptr_reg == PROT_ADDR)
               act = 1'b0;
            else
            begin
               mem[{nv_sel, ptr_reg}] = sh_reg;
               ptr_reg[1:0] = ptr_reg[1:0] + 2'h1;
            end
            pull_low = act;
         end
         else if (bc == 9)
         begin
            bc = 0;
            nb = nb + 1;
            if (rd)
            begin
               sh_reg = mem[{nv_sel, ptr_reg}];
               rc = nv_sel && ptr_reg[1:0] == 2'h0 && !rc;
               if (rc)
                  sh_reg = ~sh_reg;
               ptr_reg = ptr_reg + 8'h01;
            end
         end
         if (rd && nb > 0 && bc < 8)
            pull_low = !sh_reg[7 - bc];
      end
endmodule  // isma_dev_model
`default_nettype wire

// ### isma_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host testbench
// ****
module isma_host_tb import isma_pkg::*;;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_len = 8'h00;
   logic memory_select_bit = 1'b0;
   logic [6:0] slave_addr = 7'h28;
   logic wr_valid = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic cmd_ready, wr_ready, rd_valid, done, nack_err, refused, busy, scl, sda_o, sda_oe_n, pull_low;
   logic [7:0] rd_data;
   logic got_nack, got_ref, saw_scl;
   logic [7:0] wq [$];
   logic [7:0] rq [$];
   int error_cnt = 0;
   int checks_done = 0;
   wire sda;
   // Open-drain line with pull-up
   assign sda = (sda_oe_n | sda_o) & ~pull_low;
   // Clock
   initial
      forever #4 clk = ~clk;
   isma_host #(.QTR_CYC_P(4), .WR_GAP_CYC(20), .RECALL_CYC(10)) uut (
      .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .memory_select_bit(memory_select_bit),
      .slave_addr(slave_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err), .refused(refused),
      .busy(busy), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   isma_dev_model dev (.scl(scl), .sda(sda), .nv_sel(memory_select_bit), .pull_low(pull_low));
   // Verdict
   task automatic end_of_test;
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One command: feed write bytes, collect read bytes, wait for done
   task automatic run(input logic [1:0] op, input logic [7:0] a, input logic [7:0] n, input logic nv);
      logic tk;
      logic wt;
      got_nack = 1'b0;
      got_ref = 1'b0;
      saw_scl = 1'b0;
      rq = {};
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_len <= n;
      memory_select_bit <= nv;
      for (int i = 0; i < 20000; i++)
      begin
         @(negedge clk);
         tk = cmd_valid & cmd_ready;
         wt = wr_valid & wr_ready;
         saw_scl |= !scl;
         got_nack |= nack_err;
         got_ref |= refused;
         if (rd_valid)
            rq.push_back(rd_data);
         if (done)
         begin
            chk("busy at done", 8'h01, {7'h00, busy});
            return;
         end
         @(posedge clk);
         if (tk)
            cmd_valid <= 1'b0;
         if (wt)
            wr_valid <= 1'b0;
         else if (wr_ready && !wr_valid)
         begin
            wr_valid <= 1'b1;
            wr_data <= (wq.size() > 0) ? wq.pop_front() : wr_data;
         end
      end
      error_cnt++;
      $display("MISMATCH done expected 1 seen 0");
      end_of_test();
   endtask
   // Byte write then random read back
   task automatic t_byte;
      wq = {8'h5a};
      run(OP_WRITE, 8'h10, 8'h01, 1'b0);
      chk("byte write nack", 8'h00, {7'h00, got_nack});
      run(OP_RAND_READ, 8'h10, 8'h01, 1'b0);
      chk("random read", 8'h5a, rq[0]);
   endtask
   // Six-byte page write from offset 2, wrapping read, current read
   task automatic t_page;
      wq = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
      run(OP_WRITE, 8'h22, 8'h06, 1'b0);
      run(OP_RAND_READ, 8'h20, 8'h04, 1'b0);
      chk("page read count", 8'h04, 8'(rq.size()));
      for (int i = 0; i < 4; i++)
         chk("page byte", 8'h33 + 8'(i * 17), rq[i]);
      run(OP_RAND_READ, 8'hff, 8'h02, 1'b0);
      chk("wrap byte ff", 8'h5a, rq[0]);
      chk("wrap byte 00", 8'ha5, rq[1]);
      run(OP_CUR_READ, 8'h00, 8'h01, 1'b0);
      chk("current read", 8'ha4, rq[0]);
   endtask
   // Commands refused without bus activity
   task automatic t_refuse;
      logic [7:0] adr [5] = '{8'h10, 8'h58, 8'h7f, 8'hac, 8'h10};
      logic [7:0] cnt [5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h02};
      for (int i = 0; i < 5; i++)
      begin
         run(OP_WRITE, adr[i], cnt[i], i == 4);
         chk("refused", 8'h01, {7'h00, got_ref});
         chk("bus idle", 8'h00, {7'h00, saw_scl});
      end
   endtask
   // Foreign address and protected write go unacknowledged
   task automatic t_nack;
      @(posedge clk);
      slave_addr <= 7'h29;
      wq = {8'h01};
      run(OP_WRITE, 8'h10, 8'h01, 1'b0);
      chk("foreign address nack", 8'h01, {7'h00, got_nack});
      @(posedge clk);
      slave_addr <= 7'h28;
      wq = {8'h99};
      run(OP_WRITE, 8'h41, 8'h01, 1'b1);
      chk("protected write nack", 8'h01, {7'h00, got_nack});
   endtask
   // Nonvolatile page-first write and recall read
   task automatic t_nv;
      wq = {8'h77};
      run(OP_WRITE, 8'h44, 8'h01, 1'b1);
      run(OP_RAND_READ, 8'h44, 8'h01, 1'b1);
      chk("recall read", 8'h77, rq[0]);
      chk("recall read count", 8'h01, 8'(rq.size()));
      run(OP_RAND_READ, 8'h44, 8'h01, 1'b0);
      chk("shadow untouched", 8'he1, rq[0]);
   endtask
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_byte();
      t_page();
      t_refuse();
      t_nack();
      t_nv();
      end_of_test();
   end
endmodule  // isma_host_tb
`default_nettype wire
